// ==== hdl/boot_select.sv ====
// dual partition flash boot select and address mapper
// assumes config words sampled from flash by the nvm loader; all inputs but arst_n_i synchronous
`timescale 1ns/1ns

module boot_select
  import boot_select_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               arst_n_i,
  // config words as read by the loader
  input  wire cfg_t               cfg_i,
  input  wire logic               cfg_valid_i,
  // security of the inactive partition and code protection of the active one
  input  wire logic               inact_wr_protect_i,
  input  wire logic               inact_rd_protect_i,
  input  wire logic               act_code_protect_i,
  // cpu side
  input  wire logic               swap_exec_i,
  input  wire logic [ADDR_W-1:0]  fetch_addr_i,
  input  wire logic               acc_wr_i,
  input  wire logic               acc_erase_i,
  input  wire logic               acc_chip_erase_i,
  input  wire logic               acc_debug_i,
  // register port
  input  wire logic [3:0]         reg_addr_i,
  input  wire logic [15:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic [15:0]             reg_rdata_o,
  // results
  output logic                    cpu_reset_hold_o,
  output logic                    p2_active_o,
  output logic [ADDR_W-1:0]       phys_addr_o,
  output region_t                 region_o,
  output logic                    acc_allow_o,
  output logic [ADDR_W-1:0]       alt_vt_base_o
);

  // sequence word: low 12 bits number, high 12 bits its complement
  function automatic logic seq_ok(input logic [BTSEQ_W-1:0] w);
    seq_ok = (w[BTSEQ_W-1:BTSEQ_NUM_W] == ~w[BTSEQ_NUM_W-1:0]);
  endfunction : seq_ok

  function automatic logic in_win(input logic [23:0] a,
                                  input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction : in_win

  load_state_t       state_r;
  load_state_t       state_nxt;
  logic [2:0]        cnt_r;
  cfg_t              cfg_r;
  logic              reset_sel_r;
  logic              p2_active_r;
  logic              hold_r;
  logic [15:0]       rdata_r;
  logic [ADDR_W-1:0] phys_r;
  region_t           region_r;
  logic              allow_r;
  logic [ADDR_W-1:0] alt_base_r;

  // boot segment limit in address units, shared by two decodes
  function automatic logic [ADDR_W-1:0] bs_lim_addr(input logic [BS_LIM_W-1:0] lim);
    bs_lim_addr = ADDR_W'(lim) * BS_LIM_SCALE;
  endfunction : bs_lim_addr

  // reset-time choice
  logic                   ok1;
  logic                   ok2;
  logic [BTSEQ_NUM_W-1:0] n1;
  logic [BTSEQ_NUM_W-1:0] n2;
  logic                   pick_p2;
  // swap
  logic                   swap_reg;
  logic                   swap_now;
  // address decode
  logic                   inact_hit;
  logic                   to_p2;
  logic [ADDR_W-1:0]      logical;
  logic [ADDR_W-1:0]      part_top;
  logic [ADDR_W-1:0]      bs_top;
  logic [ADDR_W-1:0]      alt_base;
  logic [ADDR_W-1:0]      alt_end;
  logic [ADDR_W-1:0]      bs_end;
  logic                   alt_en;
  logic                   is_otp;
  logic                   is_fix;
  logic                   is_pri;
  logic                   is_alt;
  logic                   is_bs;
  logic                   is_range;
  logic                   is_gs;
  logic [ADDR_W-1:0]      phys_nxt;
  region_t                region_nxt;
  // access check
  logic                   acc_any;
  logic                   otp_ok;
  logic                   inact_ok;
  logic                   act_ok;
  logic                   allow;
  // register read mux
  logic [15:0]            ctrl_word;
  logic [15:0]            stat_word;
  logic [15:0]            rd_mux;

  assign ok1     = seq_ok(cfg_r.seq1);
  assign ok2     = seq_ok(cfg_r.seq2);
  assign n1      = cfg_r.seq1[BTSEQ_NUM_W-1:0];
  assign n2      = cfg_r.seq2[BTSEQ_NUM_W-1:0];
  assign pick_p2 = cfg_r.dual_mode &&
                   ((ok2 && !ok1) ||
                    (ok1 && ok2 && (n2 < n1)));

  // swap command over the register port as well as the cpu strobe
  assign swap_reg = reg_wr_i && (reg_addr_i == SWAP_CMD_ADDR) &&
                    (reg_wdata_i == SWAP_KEY);
  assign swap_now = (state_r == ST_RUN) && cfg_r.dual_mode &&
                    (swap_exec_i || swap_reg);

  assign inact_hit = cfg_r.dual_mode && fetch_addr_i[PART_SEL_BIT];
  assign to_p2     = cfg_r.dual_mode && (p2_active_r ^ fetch_addr_i[PART_SEL_BIT]);
  assign logical   = {1'b0, 1'b0, fetch_addr_i[PART_SEL_BIT-1:0]};
  assign part_top  = cfg_r.dual_mode ? PART_TOP : SINGLE_TOP;
  assign bs_top    = bs_lim_addr(cfg_r.bs_limit);
  assign alt_base  = cfg_r.bs_present ? (bs_top - ALT_VT_BS_OFFSET)
                                      : ALT_VT_LO;
  assign alt_end   = cfg_r.bs_present ? (alt_base + (ALT_VT_HI - ALT_VT_LO))
                                      : ALT_VT_HI;
  assign bs_end    = cfg_r.bs_present ? (bs_top - 24'h000001) : FIXED_VEC_END;
  assign alt_en    = cfg_r.alt_vt_disable_n;
  assign is_otp    = in_win(fetch_addr_i, OTP_LO, OTP_HI);
  assign is_fix    = !is_otp && (logical < FIXED_VEC_END);
  assign is_pri    = !is_otp && in_win(logical, PRI_VT_LO, PRI_VT_HI);
  assign is_alt    = !is_otp && alt_en && in_win(logical, alt_base, alt_end);
  assign is_bs     = !is_otp && cfg_r.bs_present && !is_alt &&
                     (logical >= FIXED_VEC_END) && (logical <= bs_end);
  assign is_range  = is_otp || (!fetch_addr_i[ADDR_W-1] && (logical <= part_top) &&
                     (cfg_r.dual_mode || !fetch_addr_i[PART_SEL_BIT]));
  assign is_gs     = !is_otp && is_range && !is_fix && !is_bs && !is_alt;

  // configuration space sits above the partitions and is never swapped
  assign phys_nxt  = fetch_addr_i[ADDR_W-1] ? fetch_addr_i :
                     (to_p2 ? (logical | INACTIVE_BASE) : logical);

  assign region_nxt.hit_otp       = is_otp;
  assign region_nxt.hit_fixed_vec = is_fix;
  assign region_nxt.hit_pri_vt    = is_pri;
  assign region_nxt.hit_alt_vt    = is_alt;
  assign region_nxt.hit_boot_seg  = is_bs;
  assign region_nxt.hit_gen_seg   = is_gs;
  assign region_nxt.to_partition2 = to_p2;
  assign region_nxt.in_range      = is_range;

  assign acc_any  = acc_wr_i || acc_erase_i || acc_chip_erase_i;
  assign otp_ok   = !(acc_erase_i || acc_chip_erase_i);
  assign inact_ok = !(inact_wr_protect_i && acc_any) &&
                    !(inact_rd_protect_i && !acc_any);
  assign act_ok   = !act_code_protect_i || acc_debug_i;
  assign allow    = (state_r == ST_RUN) && is_range &&
                    (is_otp ? otp_ok : (inact_hit ? inact_ok : act_ok));

  assign ctrl_word = 16'(p2_active_r) << P2_ACTIVE_BIT;
  assign stat_word = {12'h000, reset_sel_r, cfg_r.dual_mode, cfg_r.bs_present, hold_r};
  assign rd_mux    = !reg_rd_i ? 16'h0000 :
                     (reg_addr_i == NVM_CTRL_ADDR) ? ctrl_word :
                     (reg_addr_i == MAP_STAT_ADDR) ? stat_word : 16'h0000;

  // loader sequence
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD:
      begin
        if (cfg_valid_i && (cnt_r == 3'(LOAD_CYCLES - 1)))
          state_nxt = ST_EVAL;
      end
      ST_EVAL: state_nxt = ST_RUN;
      ST_RUN:  state_nxt = ST_RUN;
      default: state_nxt = ST_LOAD;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r <= ST_LOAD;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_r <= 3'h0;
    end
    else if (state_r == ST_LOAD && cfg_valid_i && cnt_r != 3'(LOAD_CYCLES - 1))
    begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // config is captured only during the reset load
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_r <= '0;
    end
    else if (state_r == ST_LOAD && cfg_valid_i)
    begin
      cfg_r <= cfg_i;
    end
  end

  // reset choice is kept apart so a swap never disturbs it
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reset_sel_r <= 1'b0;
    end
    else if (state_r == ST_EVAL)
    begin
      reset_sel_r <= pick_p2;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      p2_active_r <= 1'b0;
    end
    else if (state_r == ST_EVAL)
    begin
      p2_active_r <= pick_p2;
    end
    else if (swap_now)
    begin
      p2_active_r <= ~p2_active_r;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hold_r <= 1'b1;
    end
    else
    begin
      hold_r <= (state_nxt != ST_RUN);
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_r <= 16'h0000;
    end
    else
    begin
      rdata_r <= rd_mux;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      phys_r <= 24'h000000;
    end
    else
    begin
      phys_r <= phys_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      region_r <= '0;
    end
    else
    begin
      region_r <= region_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      allow_r <= 1'b0;
    end
    else
    begin
      allow_r <= allow;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      alt_base_r <= ALT_VT_LO;
    end
    else
    begin
      alt_base_r <= alt_en ? alt_base : ALT_VT_LO;
    end
  end

  assign reg_rdata_o      = rdata_r;
  assign cpu_reset_hold_o = hold_r;
  assign p2_active_o      = p2_active_r;
  assign phys_addr_o      = phys_r;
  assign region_o         = region_r;
  assign acc_allow_o      = allow_r;
  assign alt_vt_base_o    = alt_base_r;

endmodule : boot_select

// ==== hdl/boot_select_pkg.sv ====
// boot select package: address map, config word layout, register map
// assumes a 24-bit program address bus and a 16-bit register port
package boot_select_pkg;

  localparam int          ADDR_W           = 24;
  localparam logic [23:0] ACTIVE_BASE      = 24'h000000;
  localparam logic [23:0] INACTIVE_BASE    = 24'h400000;
  localparam int          PART_SEL_BIT     = 22;
  localparam logic [23:0] RESET_VECTOR     = 24'h000000;
  localparam logic [23:0] START_PTR_ADDR   = 24'h000002;
  localparam logic [23:0] FIXED_VEC_END    = 24'h000200;
  localparam logic [23:0] PRI_VT_LO        = 24'h000004;
  localparam logic [23:0] PRI_VT_HI        = 24'h0000FF;
  localparam logic [23:0] ALT_VT_LO        = 24'h000104;
  localparam logic [23:0] ALT_VT_HI        = 24'h0001FF;
  localparam logic [23:0] BS_LIM_SCALE     = 24'd1024;
  localparam logic [23:0] ALT_VT_BS_OFFSET = 24'd508;
  localparam int          BS_LIM_W         = 13;
  localparam logic [23:0] BTSEQ_ACTIVE     = 24'h055FFC;
  localparam logic [23:0] BTSEQ_INACTIVE   = 24'h455FFC;
  localparam logic [23:0] OTP_LO           = 24'h801700;
  localparam logic [23:0] OTP_HI           = 24'h8017FE;
  localparam logic [23:0] PART_TOP         = 24'h055FFE;
  localparam logic [23:0] SINGLE_TOP       = 24'h0ABFFE;
  localparam int          BTSEQ_W          = 24;
  localparam int          BTSEQ_NUM_W      = 12;
  localparam int          LOAD_CYCLES      = 4;

  // register port map
  localparam logic [3:0]  NVM_CTRL_ADDR    = 4'h0;
  localparam logic [3:0]  MAP_STAT_ADDR    = 4'h1;
  localparam logic [3:0]  SWAP_CMD_ADDR    = 4'h2;
  localparam int          P2_ACTIVE_BIT    = 10;
  localparam logic [15:0] SWAP_KEY         = 16'h00A5;

  typedef struct packed {
    logic [23:0] seq1;
    logic [23:0] seq2;
    logic        dual_mode;
    logic        alt_vt_disable_n;
    logic        bs_present;
    logic [12:0] bs_limit;
  } cfg_t;

  typedef struct packed {
    logic        hit_otp;
    logic        hit_fixed_vec;
    logic        hit_pri_vt;
    logic        hit_alt_vt;
    logic        hit_boot_seg;
    logic        hit_gen_seg;
    logic        to_partition2;
    logic        in_range;
  } region_t;

  typedef enum logic [1:0] {ST_LOAD, ST_EVAL, ST_RUN} load_state_t;

endpackage : boot_select_pkg

// ==== verification/boot_select_chk.sv ====
// checker for boot_select: swap, register read, decode and hold relations
// assumes binding to every boot_select instance
`timescale 1ns/1ns

module boot_select_chk
  import boot_select_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        arst_n_i,
  input wire cfg_t        cfg_i,
  input wire logic        swap_exec_i,
  input wire logic [23:0] fetch_addr_i,
  input wire logic        acc_erase_i,
  input wire logic        acc_chip_erase_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        cpu_reset_hold_o,
  input wire logic        p2_active_o,
  input wire logic [23:0] phys_addr_o,
  input wire region_t     region_o,
  input wire logic        acc_allow_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  wire run    = !cpu_reset_hold_o;
  wire any_wr = reg_wr_i && reg_addr_i == SWAP_CMD_ADDR;
  wire key_wr = any_wr && reg_wdata_i == SWAP_KEY;
  wire in_pri = fetch_addr_i >= PRI_VT_LO && fetch_addr_i <= PRI_VT_HI;
  wire in_otp = fetch_addr_i >= OTP_LO && fetch_addr_i <= OTP_HI;

  swap_toggle_a: assert property (run && cfg_i.dual_mode && (swap_exec_i || key_wr)
    |=> p2_active_o != $past(p2_active_o)) else $error("swap left partition unchanged");
  part_keep_a: assert property (run && !swap_exec_i && !any_wr
    |=> $stable(p2_active_o)) else $error("partition changed without swap");
  ctrl_read_a: assert property (reg_rd_i && reg_addr_i == NVM_CTRL_ADDR
    |=> reg_rdata_o[P2_ACTIVE_BIT] == $past(p2_active_o)) else $error("flag read wrong");
  rd_quiet_a: assert property (!reg_rd_i || reg_addr_i > SWAP_CMD_ADDR
    |=> reg_rdata_o == 16'h0000) else $error("read data not zero");
  addr_map_a: assert property (run && cfg_i.dual_mode && !fetch_addr_i[23] |=> phys_addr_o ==
    ($past(fetch_addr_i) ^ {1'b0, $past(p2_active_o), 22'h0})) else $error("bad mapping");
  pri_table_a: assert property (run && fetch_addr_i[23:22] == 2'b00
    |=> region_o.hit_pri_vt == $past(in_pri)) else $error("primary table decode wrong");
  otp_erase_a: assert property (run && in_otp && (acc_erase_i || acc_chip_erase_i)
    |=> !acc_allow_o) else $error("erase of one-time area allowed");
  hold_block_a: assert property (cpu_reset_hold_o |-> !acc_allow_o)
    else $error("access allowed during hold");
  hold_load_a: assert property ($rose(arst_n_i) |-> cpu_reset_hold_o [*4])
    else $error("hold dropped before load");

  cover property (run && swap_exec_i);
  cover property (reg_rd_i && reg_addr_i == NVM_CTRL_ADDR && p2_active_o);
  cover property (run && in_otp && acc_erase_i);
endmodule : boot_select_chk

bind boot_select boot_select_chk u_boot_select_chk (.*);

// ==== verification/boot_select_tb_top.sv ====
// testbench for boot_select: reset choice, swap, register port, decode
// assumes a 25 MHz clock and decode results one cycle after the fetch
`timescale 1ns/1ns

module boot_select_tb_top;
  import boot_select_pkg::*;
  logic        mclk_i, arst_n_i, cfg_valid_i, swap_exec_i, reg_wr_i, reg_rd_i, acc_debug_i;
  logic        inact_wr_protect_i, inact_rd_protect_i, act_code_protect_i, acc_wr_i;
  logic        acc_erase_i, acc_chip_erase_i, cpu_reset_hold_o, p2_active_o, acc_allow_o;
  logic        rd_d, fe_d, fe_on, ep;
  cfg_t        cfg_i;
  region_t     region_o;
  logic [3:0]  reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o;
  logic [23:0] fetch_addr_i, phys_addr_o, alt_vt_base_o;
  logic [11:0] r1, r2;
  logic [15:0] rd_q[$];
  logic [25:0] fe_q[$];
  int          failures, n_tests;

  boot_select u_boot_select (.mclk_i, .arst_n_i, .cfg_i, .cfg_valid_i, .inact_wr_protect_i,
    .inact_rd_protect_i, .act_code_protect_i, .swap_exec_i, .fetch_addr_i, .acc_wr_i,
    .acc_erase_i, .acc_chip_erase_i, .acc_debug_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .cpu_reset_hold_o, .p2_active_o, .phys_addr_o, .region_o,
    .acc_allow_o, .alt_vt_base_o);

  always #20 mclk_i = ~mclk_i;

  task automatic chk(input string nm, input logic [25:0] e, input logic [25:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic report_and_stop;
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // result watcher: oldest note against what appears
  always @(posedge mclk_i)
  begin
    rd_d <= reg_rd_i;
    fe_d <= fe_on;
    if (rd_d)
      chk("rdata", rd_q.pop_front(), reg_rdata_o);
    if (fe_d)
      chk("decode", fe_q.pop_front(), {acc_allow_o, region_o.hit_pri_vt, phys_addr_o});
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick

  function automatic logic [23:0] sq(input logic [11:0] n);
    return {~n, n};
  endfunction : sq

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    rd_q.push_back(e);
    tick(1);
    reg_rd_i <= 1'b0;
    tick(1);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    tick(1);
    reg_wr_i <= 1'b0;
    tick(1);
  endtask : wr

  task automatic fe(input logic [23:0] a, input logic [3:0] k, input logic al, input logic pr);
    fetch_addr_i <= a;
    {acc_wr_i, acc_erase_i, acc_chip_erase_i, acc_debug_i} <= k;
    fe_on <= 1'b1;
    fe_q.push_back({al, pr, a[23] ? a : a ^ {1'b0, ep, 22'h0}});
    tick(1);
    fe_on <= 1'b0;
    tick(1);
  endtask : fe

  task automatic boot(input logic [23:0] s1, input logic [23:0] s2, input logic dm, input logic e);
    int n;
    arst_n_i <= 1'b0;
    cfg_valid_i <= 1'b0;
    cfg_i.seq1 <= s1;
    cfg_i.seq2 <= s2;
    cfg_i.dual_mode <= dm;
    tick(8);
    arst_n_i <= 1'b1;
    cfg_valid_i <= 1'b1;
    for (n = 0; n < 50 && cpu_reset_hold_o !== 1'b0; n++)
      tick(1);
    if (n == 50)
    begin
      failures++;
      report_and_stop();
    end
    ep = e;
    chk("p2", e, p2_active_o);
    chk("alt", cfg_i.bs_present ? {cfg_i.bs_limit, 10'h0} - ALT_VT_BS_OFFSET : ALT_VT_LO,
        alt_vt_base_o);
    rd(NVM_CTRL_ADDR, {5'h0, e, 10'h0});
  endtask : boot

  task automatic swp(input logic key, input logic dm);
    if (key)
      wr(SWAP_CMD_ADDR, SWAP_KEY);
    else
    begin
      swap_exec_i <= 1'b1;
      tick(1);
      swap_exec_i <= 1'b0;
      tick(1);
    end
    ep ^= dm;
    chk("p2", ep, p2_active_o);
  endtask : swp

  initial
  begin
    {mclk_i, arst_n_i, cfg_valid_i, swap_exec_i, reg_wr_i, reg_rd_i, acc_debug_i} = '0;
    {inact_wr_protect_i, inact_rd_protect_i, act_code_protect_i, acc_wr_i} = '0;
    {acc_erase_i, acc_chip_erase_i, rd_d, fe_d, fe_on, ep} = '0;
    {reg_addr_i, reg_wdata_i, fetch_addr_i} = '0;
    cfg_i = '0;
    cfg_i.alt_vt_disable_n = 1'b1;
    void'($urandom(65167));
    boot(sq(12'h005), sq(12'h003), 1'b1, 1'b1);
    boot(sq(12'h007), sq(12'h007), 1'b1, 1'b0);
    boot(24'h123123, 24'h456456, 1'b1, 1'b0);
    boot(24'h123123, sq(12'h009), 1'b1, 1'b1);
    boot(sq(12'h009), 24'h456456, 1'b1, 1'b0);
    boot(sq(12'h009), sq(12'h001), 1'b0, 1'b0);
    swp(1'b0, 1'b0);
    fe(24'h000100, 4'h0, 1'b1, 1'b0);
    r1 = 12'($urandom);
    r2 = 12'($urandom);
    boot(sq(r1), sq(r2), 1'b1, r2 < r1);
    cfg_i.bs_present <= 1'b1;
    cfg_i.bs_limit <= 13'h0010;
    boot(sq(12'h005), sq(12'h003), 1'b1, 1'b1);
    fe(24'h000100, 4'h0, 1'b1, 1'b0);
    fe(24'h400100, 4'h0, 1'b1, 1'b0);
    swp(1'b0, 1'b1);
    fe(24'h000100, 4'h0, 1'b1, 1'b0);
    swp(1'b1, 1'b1);
    wr(SWAP_CMD_ADDR, 16'h00A4);
    wr(NVM_CTRL_ADDR, 16'hFFFF);
    rd(NVM_CTRL_ADDR, {5'h0, ep, 10'h0});
    rd(4'hF, 16'h0000);
    swp(1'b1, 1'b1);
    cfg_i.seq1 <= sq(12'h00F);
    tick(4);
    chk("p2", ep, p2_active_o);
    boot(sq(12'h005), sq(12'h003), 1'b1, 1'b1);
    fe(24'h000004, 4'h0, 1'b1, 1'b1);
    fe(24'h0000FF, 4'h0, 1'b1, 1'b1);
    fe(24'h801700, 4'h4, 1'b0, 1'b0);
    fe(24'h801700, 4'h2, 1'b0, 1'b0);
    fe(24'h8017FE, 4'h8, 1'b1, 1'b0);
    inact_rd_protect_i <= 1'b1;
    fe(24'h400200, 4'h0, 1'b0, 1'b0);
    inact_wr_protect_i <= 1'b1;
    fe(24'h400200, 4'h8, 1'b0, 1'b0);
    act_code_protect_i <= 1'b1;
    fe(24'h000300, 4'h0, 1'b0, 1'b0);
    fe(24'h000300, 4'h1, 1'b1, 1'b0);
    tick(2);
    report_and_stop();
  end
endmodule : boot_select_tb_top
